// file: rtl/cvu_top.sv
/*
  Converter value update logic: control, data byte pair, shadow load by
  register write or selected trigger flag, output gating.
  Assumes a classic Wishbone master and synchronous trigger flag inputs.
*/
// Chosen here: the register addresses and register access over Wishbone.
// Functional notes
// - The alignment control picks left or right aligned layout of the byte pair.
// - A change of alignment reaches the converter only at the next high byte write.
// - The output pin enable routes the value to the pin, otherwise it stays internal.
// - The converter only runs while the enable control is set.
// - In left aligned mode one high byte write is a complete update.
// - Right aligned, high bits 1:0 carry value bits 9:8 and low carries bits 7:0.
// - Left aligned, high carries value bits 9:2 and low bits 7:6 carry bits 1:0.
// - The converted value comes from hidden shadow registers loaded whole.
// - With auto trigger on, the shadow loads on the selected trigger event.
// - In triggered mode a load needs low then high written for ten bits.
// - In triggered mode after a high byte write every trigger event while idle loads, until a low byte write.
// - With auto trigger off, each high byte write loads the shadow at once.
// - A low byte write alone never changes the converter output.
// - The trigger select field picks one of eight flags and its rising edge.
// - A trigger edge during a triggered conversion is ignored.
`timescale 1ns/1ps
module cvu_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [7:0]  trig_flags_i,
  output logic             converter_enable_o,
  output logic             output_pin_enable_o,
  output logic      [9:0]  converter_value_o,
  output logic      [9:0]  analog_output_pin_o,
  output logic             conversion_busy_o
);

  // Bus slave state
  logic        ack;
  logic [31:0] rdata;
  logic        next_ack;
  logic [31:0] next_rdata;
  logic        access;
  logic        wr_ctl;
  logic        wr_high;
  logic        wr_low;

  // Register state
  logic [7:0] ctl;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic       armed;
  logic       armed_align;
  logic [7:0] next_ctl;
  logic [7:0] next_high_byte;
  logic [7:0] next_low_byte;
  logic       next_armed;
  logic       next_armed_align;

  // Trigger engine state
  cvu_pkg::cvu_trig_state_type state;
  cvu_pkg::cvu_trig_state_type next_state;
  logic [6:0] count;
  logic [6:0] next_count;
  logic [7:0] rises;
  logic       sel_rise;
  logic       trig_load;

  // Shadow load path
  logic       load;
  logic       load_align;
  logic [7:0] load_high;
  logic [9:0] shadow_value;

  // Output state
  logic       en_q;
  logic       oe_q;
  logic [9:0] value_q;
  logic [9:0] pin_q;
  logic       busy_q;
  logic       next_en_q;
  logic       next_oe_q;
  logic [9:0] next_value_q;
  logic [9:0] next_pin_q;
  logic       next_busy_q;

  logic       ctl_en;
  logic       ctl_oe;
  logic       ctl_la;
  logic       ctl_ate;
  logic [2:0] ctl_tsel;
  logic [7:0] high_read;
  logic [7:0] low_read;

  assign ctl_en   = ctl[cvu_pkg::CTL_EN_BIT];
  assign ctl_oe   = ctl[cvu_pkg::CTL_OE_BIT];
  assign ctl_la   = ctl[cvu_pkg::CTL_LA_BIT];
  assign ctl_ate  = ctl[cvu_pkg::CTL_ATE_BIT];
  assign ctl_tsel = ctl[cvu_pkg::CTL_TSEL_MSB:cvu_pkg::CTL_TSEL_LSB];

  assign access  = wb_cyc_i && wb_stb_i && !ack;
  assign wr_ctl  = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0]
                   && (wb_adr_i == cvu_pkg::ADR_CONTROL);
  assign wr_high = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0]
                   && (wb_adr_i == cvu_pkg::ADR_HIGH);
  assign wr_low  = wb_cyc_i && wb_stb_i && wb_we_i && ack && wb_sel_i[0]
                   && (wb_adr_i == cvu_pkg::ADR_LOW);

  always_comb begin
    if (ctl_la) begin
      high_read = high_byte;
      low_read  = low_byte & cvu_pkg::LOW_LEFT_MASK;
    end else begin
      high_read = high_byte & cvu_pkg::HIGH_RIGHT_MASK;
      low_read  = low_byte;
    end
  end

  // Bus answer and read data
  always_comb begin
    next_ack   = access;
    next_rdata = 32'h0000_0000;
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        cvu_pkg::ADR_CONTROL: next_rdata = {24'h00_0000, ctl};
        cvu_pkg::ADR_HIGH:    next_rdata = {24'h00_0000, high_read};
        cvu_pkg::ADR_LOW:     next_rdata = {24'h00_0000, low_read};
        cvu_pkg::ADR_STATUS: begin
          next_rdata[cvu_pkg::STS_ARMED_BIT] = armed;
          next_rdata[cvu_pkg::STS_BUSY_BIT]  = (state == cvu_pkg::TRIG_BUSY);
          next_rdata[cvu_pkg::STS_VALUE_MSB:cvu_pkg::STS_VALUE_LSB] = shadow_value;
        end
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack   <= 1'b0;
      rdata <= 32'h0000_0000;
    end else begin
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  // Register writes and arming
  always_comb begin
    next_ctl         = ctl;
    next_high_byte   = high_byte;
    next_low_byte    = low_byte;
    next_armed       = armed;
    next_armed_align = armed_align;
    if (wr_ctl) begin
      next_ctl = wb_dat_i[7:0] & cvu_pkg::CTL_WRITE_MASK;
    end
    if (wr_low) begin
      next_low_byte = wb_dat_i[7:0];
      next_armed    = 1'b0;
    end
    if (wr_high) begin
      next_high_byte   = wb_dat_i[7:0];
      next_armed       = 1'b1;
      next_armed_align = ctl_la;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl         <= cvu_pkg::CTL_RESET;
      high_byte   <= cvu_pkg::HIGH_RESET;
      low_byte    <= cvu_pkg::LOW_RESET;
      armed       <= 1'b0;
      armed_align <= 1'b0;
    end else begin
      ctl         <= next_ctl;
      high_byte   <= next_high_byte;
      low_byte    <= next_low_byte;
      armed       <= next_armed;
      armed_align <= next_armed_align;
    end
  end

  cvu_rise_det #(
    .WIDTH (8)
  ) u_rise (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .flags_i (trig_flags_i),
    .rise_o  (rises)
  );

  assign sel_rise = rises[ctl_tsel];

  assign trig_load = ctl_ate && ctl_en && sel_rise && armed
                     && (state == cvu_pkg::TRIG_IDLE);

  always_comb begin
    next_state = state;
    next_count = count;
    case (state)
      cvu_pkg::TRIG_IDLE: begin
        if (trig_load) begin
          next_state = cvu_pkg::TRIG_BUSY;
          next_count = cvu_pkg::CONV_CYCLES - 7'h01;
        end
      end
      cvu_pkg::TRIG_BUSY: begin
        if (count == 7'h00) begin
          next_state = cvu_pkg::TRIG_IDLE;
        end else begin
          next_count = count - 7'h01;
        end
      end
      default: begin
        next_state = cvu_pkg::TRIG_IDLE;
        next_count = 7'h00;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= cvu_pkg::TRIG_IDLE;
      count <= 7'h00;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  // triggered load when auto trigger set
  always_comb begin
    if (ctl_ate) begin
      load       = trig_load;
      load_align = armed_align;
      load_high  = high_byte;
    end else begin
      load       = wr_high;
      load_align = ctl_la;
      load_high  = wb_dat_i[7:0];
    end
  end

  cvu_shadow u_shadow (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .load_i       (load),
    .left_align_i (load_align),
    .high_i       (load_high),
    .low_i        (low_byte),
    .value_o      (shadow_value)
  );

  always_comb begin
    next_en_q    = ctl_en;
    next_oe_q    = ctl_en && ctl_oe;
    next_value_q = ctl_en ? shadow_value : cvu_pkg::VALUE_RESET;
    next_pin_q   = (ctl_en && ctl_oe) ? shadow_value : cvu_pkg::VALUE_RESET;
    next_busy_q  = (next_state == cvu_pkg::TRIG_BUSY);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q    <= 1'b0;
      oe_q    <= 1'b0;
      value_q <= cvu_pkg::VALUE_RESET;
      pin_q   <= cvu_pkg::VALUE_RESET;
      busy_q  <= 1'b0;
    end else begin
      en_q    <= next_en_q;
      oe_q    <= next_oe_q;
      value_q <= next_value_q;
      pin_q   <= next_pin_q;
      busy_q  <= next_busy_q;
    end
  end

  assign wb_ack_o            = ack;
  assign wb_dat_o            = rdata;
  assign converter_enable_o  = en_q;
  assign output_pin_enable_o = oe_q;
  assign converter_value_o   = value_q;
  assign analog_output_pin_o = pin_q;
  assign conversion_busy_o   = busy_q;

  // Checks
  a_ack_single_pulse: assert property (
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_ack_after_request: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_direct_high_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_high && !ctl_ate && !ctl_la)
    |=> shadow_value == {$past(wb_dat_i[1:0]), $past(low_byte)})
    else $error("high write did not load shadow");

  a_left_high_load: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_high && !ctl_ate && ctl_la)
    |=> shadow_value[9:2] == $past(wb_dat_i[7:0]))
    else $error("left aligned load wrong");

  a_low_no_effect: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_low && !trig_load) |=> $stable(shadow_value))
    else $error("low write changed shadow");

  a_low_disarms: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (wr_low && !wr_high) |=> !armed)
    else $error("low write left trigger armed");

  a_trig_needs_arm: assert property (
    @(posedge clk_i) disable iff (rst_i)
    (ctl_ate && !armed) |=> $stable(shadow_value))
    else $error("unarmed trigger loaded shadow");

  a_busy_ignores_edge: assert property (
    @(posedge clk_i) disable iff (rst_i)
    trig_load |=> (state == cvu_pkg::TRIG_BUSY && !trig_load)[*8])
    else $error("edge accepted during conversion");

  a_disabled_zero: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !ctl_en |=> (converter_value_o == 10'h000 && !converter_enable_o))
    else $error("value driven while disabled");

  a_pin_gated: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !(ctl_en && ctl_oe) |=> analog_output_pin_o == 10'h000)
    else $error("pin driven while output disabled");

endmodule

// file: shared/cvu_pkg.sv
/*
  Constants for the converter value update block: register offsets, field
  positions, reset values, trigger engine states and timing counts.
  Assumes a 50 MHz peripheral clock and a 32-bit classic Wishbone bus.
*/
package cvu_pkg;

  // Byte offsets on the register bus
  localparam logic [3:0] ADR_CONTROL = 4'h0;
  localparam logic [3:0] ADR_HIGH    = 4'h4;
  localparam logic [3:0] ADR_LOW     = 4'h8;
  localparam logic [3:0] ADR_STATUS  = 4'hc;

  // Control register fields
  localparam int CTL_EN_BIT   = 0;
  localparam int CTL_OE_BIT   = 1;
  localparam int CTL_LA_BIT   = 2;
  localparam int CTL_TSEL_LSB = 4;
  localparam int CTL_TSEL_MSB = 6;
  localparam int CTL_ATE_BIT  = 7;

  // Writable control bits, bit 3 reads as zero
  localparam logic [7:0] CTL_WRITE_MASK = 8'hf7;

  // Used bits of the data bytes per alignment
  localparam logic [7:0] HIGH_RIGHT_MASK = 8'h03;
  localparam logic [7:0] LOW_LEFT_MASK   = 8'hc0;

  // Reset values
  localparam logic [7:0] CTL_RESET   = 8'h00;
  localparam logic [7:0] HIGH_RESET  = 8'h00;
  localparam logic [7:0] LOW_RESET   = 8'h00;
  localparam logic [9:0] VALUE_RESET = 10'h000;

  // Status register fields
  localparam int STS_ARMED_BIT = 0;
  localparam int STS_BUSY_BIT  = 1;
  localparam int STS_VALUE_LSB = 16;
  localparam int STS_VALUE_MSB = 25;

  // Triggered conversion time and its length in clock cycles
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS  = 1000;
  localparam logic [6:0] CONV_CYCLES =
    7'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  typedef enum logic {
    TRIG_IDLE,
    TRIG_BUSY
  } cvu_trig_state_type;

endpackage

// file: rtl/cvu_rise_det.sv
/*
  Rising edge detector for a group of flag inputs.
  Assumes the flags are synchronous to clk_i.
*/
`timescale 1ns/1ps
module cvu_rise_det #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] flags_i,
  output logic      [WIDTH-1:0] rise_o
);

  logic [WIDTH-1:0] prev;
  logic [WIDTH-1:0] next_prev;

  always_comb begin
    next_prev = flags_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev <= '0;
    end else begin
      prev <= next_prev;
    end
  end

  assign rise_o = flags_i & ~prev;

endmodule

// file: rtl/cvu_shadow.sv
/*
  Hidden shadow register holding the value actually converted.
  Assumes the caller presents the byte pair and alignment to load.
*/
`timescale 1ns/1ps
module cvu_shadow (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       load_i,
  input  wire logic       left_align_i,
  input  wire logic [7:0] high_i,
  input  wire logic [7:0] low_i,
  output logic      [9:0] value_o
);

  logic [9:0] value;
  logic [9:0] next_value;

  always_comb begin
    next_value = value;
    if (load_i) begin
      if (left_align_i) begin
        next_value = {high_i, low_i[7:6]};
      end else begin
        next_value = {high_i[1:0], low_i};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      value <= cvu_pkg::VALUE_RESET;
    end else begin
      value <= next_value;
    end
  end

  assign value_o = value;

endmodule

// file: verification/tb.sv
/*
  Self-checking bench for the converter value update block.
  Assumes cvu_top answers each classic Wishbone request with a one-cycle ack.
*/
`timescale 1ns/1ps
module tb;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [3:0]  wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [7:0]  trig_flags_i;
  logic        converter_enable_o;
  logic        output_pin_enable_o;
  logic [9:0]  converter_value_o;
  logic [9:0]  analog_output_pin_o;
  logic        conversion_busy_o;
  logic [31:0] rd;
  logic [9:0]  exp_v;
  logic [7:0]  hb;
  int          n_errors;
  int          total_checks;

  cvu_top i_cvu_top (
    .clk_i               (clk_i),
    .rst_i               (rst_i),
    .wb_cyc_i            (wb_cyc_i),
    .wb_stb_i            (wb_stb_i),
    .wb_we_i             (wb_we_i),
    .wb_adr_i            (wb_adr_i),
    .wb_dat_i            (wb_dat_i),
    .wb_sel_i            (wb_sel_i),
    .wb_dat_o            (wb_dat_o),
    .wb_ack_o            (wb_ack_o),
    .trig_flags_i        (trig_flags_i),
    .converter_enable_o  (converter_enable_o),
    .output_pin_enable_o (output_pin_enable_o),
    .converter_value_o   (converter_value_o),
    .analog_output_pin_o (analog_output_pin_o),
    .conversion_busy_o   (conversion_busy_o)
  );

  always #10 clk_i = ~clk_i;

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle, held until ack is sampled high
  task automatic bus(input logic we, input logic [3:0] adr, input logic [7:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_errors++;
      $display("ERROR ack expected 1 seen %b", wb_ack_o);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pulse(input int idx);
    trig_flags_i <= 8'h01 << idx;
    wait_clk(3);
    trig_flags_i <= 8'h00;
    wait_clk(3);
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (conversion_busy_o !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    check("busy end", 32'h0, {31'h0, conversion_busy_o});
  endtask

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_dat_i = 32'h00000000;
    wb_sel_i = 4'hf;
    trig_flags_i = 8'h00;
    n_errors = 0;
    total_checks = 0;
    wait_clk(2);
    rst_i <= 1'b0;
    wait_clk(1);
    bus(1'b0, cvu_pkg::ADR_HIGH, 8'h00);
    check("high reset", 32'h0, rd);
    bus(1'b0, cvu_pkg::ADR_LOW, 8'h00);
    check("low reset", 32'h0, rd);
    bus(1'b1, 4'h2, 8'hff);
    bus(1'b0, 4'h2, 8'h00);
    check("unmapped read", 32'h0, rd);
    check("value reset", 32'h0, {22'h0, converter_value_o});
    $display("test reset done");
    bus(1'b1, cvu_pkg::ADR_CONTROL, 8'h01);
    bus(1'b1, cvu_pkg::ADR_LOW, 8'h5a);
    wait_clk(3);
    check("value after low", 32'h0, {22'h0, converter_value_o});
    bus(1'b1, cvu_pkg::ADR_HIGH, 8'hff);
    wait_clk(2);
    check("value right", 32'h35a, {22'h0, converter_value_o});
    check("pin off", 32'h0, {22'h0, analog_output_pin_o});
    check("oe off", 32'h0, {31'h0, output_pin_enable_o});
    check("enable on", 32'h1, {31'h0, converter_enable_o});
    bus(1'b0, cvu_pkg::ADR_HIGH, 8'h00);
    check("high read", 32'h03, rd);
    wb_sel_i <= 4'he;
    bus(1'b1, cvu_pkg::ADR_HIGH, 8'h00);
    wb_sel_i <= 4'hf;
    bus(1'b0, cvu_pkg::ADR_HIGH, 8'h00);
    check("high no sel", 32'h03, rd);
    $display("test right align done");
    bus(1'b1, cvu_pkg::ADR_CONTROL, 8'h07);
    wait_clk(3);
    check("value kept", 32'h35a, {22'h0, converter_value_o});
    check("pin on", 32'h35a, {22'h0, analog_output_pin_o});
    check("oe on", 32'h1, {31'h0, output_pin_enable_o});
    bus(1'b1, cvu_pkg::ADR_HIGH, 8'ha5);
    wait_clk(2);
    check("value left", 32'h295, {22'h0, converter_value_o});
    bus(1'b0, cvu_pkg::ADR_LOW, 8'h00);
    check("low read", 32'h40, rd);
    $display("test left align done");
    bus(1'b1, cvu_pkg::ADR_CONTROL, 8'h06);
    wait_clk(3);
    check("enable off", 32'h0, {31'h0, converter_enable_o});
    check("value off", 32'h0, {22'h0, converter_value_o});
    check("pin idle", 32'h0, {22'h0, analog_output_pin_o});
    $display("test disable done");
    exp_v = 10'h295;
    for (int t = 0; t < 8; t++) begin
      hb = 8'h30 + 8'(t);
      bus(1'b1, cvu_pkg::ADR_CONTROL, {1'b1, 3'(t), 4'h5});
      bus(1'b1, cvu_pkg::ADR_LOW, 8'h80);
      bus(1'b1, cvu_pkg::ADR_HIGH, hb);
      wait_clk(3);
      check("no load on write", 32'(exp_v), {22'h0, converter_value_o});
      pulse((t + 1) % 8);
      check("other flag", 32'(exp_v), {22'h0, converter_value_o});
      pulse(t);
      exp_v = {hb, 2'b10};
      check("trig load", 32'(exp_v), {22'h0, converter_value_o});
      check("busy", 32'h1, {31'h0, conversion_busy_o});
      bus(1'b0, cvu_pkg::ADR_STATUS, 8'h00);
      check("status", {6'h00, exp_v, 14'h0000, 2'b11}, rd);
      bus(1'b1, cvu_pkg::ADR_HIGH, hb + 8'h40);
      pulse(t);
      check("edge in busy", 32'(exp_v), {22'h0, converter_value_o});
      wait_idle();
      pulse(t);
      exp_v = {hb + 8'h40, 2'b10};
      check("reload", 32'(exp_v), {22'h0, converter_value_o});
      wait_idle();
      bus(1'b1, cvu_pkg::ADR_LOW, 8'h00);
      pulse(t);
      check("low only", 32'(exp_v), {22'h0, converter_value_o});
      wait_idle();
    end
    $display("test trigger done");
    stop_test();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    stop_test();
  end
endmodule
